// ==== logic/mbr_branch_ctrl.v ====
`include "mbr_consts.vh"

module mbr_branch_ctrl #(
    parameter CORE_VERSION = 3,
    parameter DMEM_AW = 16,
    parameter [31:0] RESET_PC = 32'h0000_0000
) (
    input wire clk,
    input wire resetn,
    input wire crypto_reset,
    input wire start_cmd,
    input wire double_trap,
    input wire scrubber_done,
    input wire irq_pending,
    input wire insn_valid,
    input wire [7:0] insn_opcode,
    input wire [7:0] insn_subop,
    input wire [15:0] insn_imm,
    input wire [2:0] insn_len,
    input wire [31:0] insn_reg,
    input wire [31:0] cond_word,
    input wire [2:0] tgt_len,
    input wire [31:0] dmem_rdata,
    output reg insn_ready_ff,
    output reg insn_done_ff,
    output reg insn_taken_ff,
    output reg insn_invalid_ff,
    output reg [31:0] program_counter_ff,
    output reg [31:0] stack_pointer_ff,
    output reg dmem_rd_ff,
    output reg dmem_wr_ff,
    output reg [31:0] dmem_addr_ff,
    output reg [31:0] dmem_wdata_ff,
    output wire [1:0] run_state_ff,
    output wire exit_irq_ff
);
    // Sequencer states
    localparam [1:0] SQ_IDLE = 2'd0;
    localparam [1:0] SQ_LOAD = 2'd1;
    localparam [1:0] SQ_DATA = 2'd2;
    localparam [1:0] SQ_WAIT = 2'd3;

    // Decoded instruction kinds
    localparam [2:0] K_BAD = 3'd0;
    localparam [2:0] K_BRA = 3'd1;
    localparam [2:0] K_JMP = 3'd2;
    localparam [2:0] K_CALL = 3'd3;
    localparam [2:0] K_RET = 3'd4;
    localparam [2:0] K_EXIT = 3'd5;
    localparam [2:0] K_SLEEP = 3'd6;

    // Live stack bits: low two and those beyond data memory are zero
    localparam [31:0] SP_MASK =
        ((32'h0000_0001 << DMEM_AW) - 32'h0000_0001) & ~32'h0000_0003;

    reg [1:0] seq_ff;
    reg [2:0] cnt_ff;
    reg [31:0] tgt_ff;
    reg [2:0] kind;
    reg [31:0] target;
    wire cc_true;
    wire cc_valid;
    wire running;
    wire accept;
    wire exit_evt;
    wire sleep_evt;
    wire sleep_flag;
    wire [31:0] imm_sext;
    wire [31:0] imm_zext;
    wire [31:0] next_pc;
    wire [31:0] sp_dec;

    // Extra fetch cycle when the instruction spans two aligned words
    function fetch_extra;
        input [31:0] addr;
        input [2:0] len;
        reg [3:0] span;
        begin
            span = {2'b00, addr[1:0]} + {1'b0, len};
            fetch_extra = (span > `MBR_WORD_BYTES);
        end
    endfunction

    // Wait count for a taken transfer after the accepting cycle
    function [2:0] taken_wait;
        input [31:0] addr;
        input [2:0] len;
        begin
            taken_wait = `MBR_BR_TAKEN_CYC - `MBR_SEQ_OVERHEAD +
                         {2'b00, fetch_extra(addr, len)};
        end
    endfunction

    mbr_cond_eval #(
        .CORE_VERSION(CORE_VERSION)
    ) u_cond (
        .cc(insn_subop[4:0]),
        .flags(cond_word[`MBR_FLAG_W-1:0]),
        .cond(cc_true),
        .valid(cc_valid)
    );

    mbr_run_state u_run (
        .clk(clk),
        .resetn(resetn),
        .crypto_reset(crypto_reset),
        .start_cmd(start_cmd),
        .exit_evt(exit_evt),
        .double_trap(double_trap),
        .sleep_evt(sleep_evt),
        .irq_pending(irq_pending),
        .scrubber_done(scrubber_done),
        .run_state_ff(run_state_ff),
        .exit_irq_ff(exit_irq_ff)
    );

    // Operand forms and derived addresses
    assign imm_sext = (insn_opcode == `MBR_OP_IMM16) ?
                      {{16{insn_imm[15]}}, insn_imm} :
                      {{24{insn_imm[7]}}, insn_imm[7:0]};
    assign imm_zext = (insn_opcode == `MBR_OP_IMM16) ?
                      {16'h0000, insn_imm} :
                      {24'h00_0000, insn_imm[7:0]};
    assign next_pc = program_counter_ff + {29'h0000_0000, insn_len};
    assign sp_dec = (stack_pointer_ff - `MBR_SP_STEP) & SP_MASK;
    assign sleep_flag = cond_word[insn_imm[4:0]];

    // Instructions are taken only while running and the sequencer is free
    assign running = (run_state_ff == `MBR_RUN_RUNNING);
    assign accept = insn_valid & insn_ready_ff & running & ~crypto_reset;
    assign exit_evt = accept & (kind == K_EXIT);
    assign sleep_evt = accept & (kind == K_SLEEP) & sleep_flag;

    // Instruction decode and transfer target
    always @* begin
        kind = K_BAD;
        target = imm_zext;
        case (insn_opcode)
            `MBR_OP_IMM8, `MBR_OP_IMM16: begin
                if (insn_subop < `MBR_SUB_COND_LIM) begin
                    if (cc_valid)
                        kind = K_BRA;
                    target = program_counter_ff + imm_sext;
                end else if (insn_subop == `MBR_SUB_JMP_I) begin
                    kind = K_JMP;
                end else if (insn_subop == `MBR_SUB_CALL_I) begin
                    kind = K_CALL;
                end else if (insn_subop == `MBR_SUB_SLEEP &&
                             insn_opcode == `MBR_OP_IMM8) begin
                    kind = K_SLEEP;
                end
            end
            `MBR_OP_CTL: begin
                if (insn_subop == `MBR_SUB_RET)
                    kind = K_RET;
                else if (insn_subop == `MBR_SUB_EXIT)
                    kind = K_EXIT;
            end
            `MBR_OP_REG: begin
                target = insn_reg;
                if (insn_subop == `MBR_SUB_JMP_R)
                    kind = K_JMP;
                else if (insn_subop == `MBR_SUB_CALL_R)
                    kind = K_CALL;
            end
            default: kind = K_BAD;
        endcase
    end

    // Sequencer, program counter, stack pointer and data memory strobes
    always @(posedge clk) begin
        if (!resetn) begin
            seq_ff <= SQ_IDLE;
            cnt_ff <= 3'h0;
            tgt_ff <= 32'h0000_0000;
            insn_ready_ff <= 1'b1;
            insn_done_ff <= 1'b0;
            insn_taken_ff <= 1'b0;
            insn_invalid_ff <= 1'b0;
            program_counter_ff <= RESET_PC;
            stack_pointer_ff <= 32'h0000_0000;
            dmem_rd_ff <= 1'b0;
            dmem_wr_ff <= 1'b0;
            dmem_addr_ff <= 32'h0000_0000;
            dmem_wdata_ff <= 32'h0000_0000;
        end else begin
            insn_done_ff <= 1'b0;
            insn_taken_ff <= 1'b0;
            insn_invalid_ff <= 1'b0;
            dmem_rd_ff <= 1'b0;
            dmem_wr_ff <= 1'b0;
            if (crypto_reset) begin
                // Abandon any transfer in flight
                seq_ff <= SQ_IDLE;
                insn_ready_ff <= 1'b1;
            end else begin
                case (seq_ff)
                    SQ_IDLE: begin
                        if (accept) begin
                            case (kind)
                                K_BRA: begin
                                    if (cc_true) begin
                                        seq_ff <= SQ_WAIT;
                                        insn_ready_ff <= 1'b0;
                                        tgt_ff <= target;
                                        cnt_ff <= taken_wait(target,
                                                             tgt_len);
                                    end else begin
                                        program_counter_ff <= next_pc;
                                        insn_done_ff <= 1'b1;
                                    end
                                end
                                K_JMP: begin
                                    seq_ff <= SQ_WAIT;
                                    insn_ready_ff <= 1'b0;
                                    tgt_ff <= target;
                                    cnt_ff <= taken_wait(target, tgt_len);
                                end
                                K_CALL: begin
                                    seq_ff <= SQ_WAIT;
                                    insn_ready_ff <= 1'b0;
                                    tgt_ff <= target;
                                    cnt_ff <= taken_wait(target, tgt_len);
                                    stack_pointer_ff <= sp_dec;
                                    dmem_wr_ff <= 1'b1;
                                    dmem_addr_ff <= sp_dec;
                                    dmem_wdata_ff <= next_pc;
                                end
                                K_RET: begin
                                    seq_ff <= SQ_LOAD;
                                    insn_ready_ff <= 1'b0;
                                    dmem_rd_ff <= 1'b1;
                                    dmem_addr_ff <= stack_pointer_ff;
                                end
                                K_EXIT: begin
                                    program_counter_ff <= next_pc;
                                    insn_done_ff <= 1'b1;
                                end
                                K_SLEEP: begin
                                    // Counter stays on the sleep itself when sleep_flag is set, else moves past it
                                    if (!sleep_flag)
                                        program_counter_ff <= next_pc;
                                    insn_done_ff <= 1'b1;
                                end
                                default: insn_invalid_ff <= 1'b1;
                            endcase
                        end
                    end
                    SQ_LOAD: seq_ff <= SQ_DATA;
                    SQ_DATA: begin
                        // Return word arrives; one cycle more than a branch
                        seq_ff <= SQ_WAIT;
                        tgt_ff <= dmem_rdata;
                        cnt_ff <= `MBR_BR_TAKEN_CYC - `MBR_RET_OVERHEAD +
                                  {2'b00, fetch_extra(dmem_rdata, tgt_len)};
                        stack_pointer_ff <=
                            (stack_pointer_ff + `MBR_SP_STEP) & SP_MASK;
                    end
                    SQ_WAIT: begin
                        if (cnt_ff == 3'h0) begin
                            seq_ff <= SQ_IDLE;
                            insn_ready_ff <= 1'b1;
                            program_counter_ff <= tgt_ff;
                            insn_done_ff <= 1'b1;
                            insn_taken_ff <= 1'b1;
                        end else begin
                            cnt_ff <= cnt_ff - 3'h1;
                        end
                    end
                    default: seq_ff <= SQ_IDLE;
                endcase
            end
        end
    end
endmodule // mbr_branch_ctrl

// ==== logic/mbr_consts.vh ====
`ifndef MBR_CONSTS_VH
`define MBR_CONSTS_VH

// Opcodes handled by the branch and run-state block
`define MBR_OP_IMM8 8'hf4
`define MBR_OP_IMM16 8'hf5
`define MBR_OP_CTL 8'hf8
`define MBR_OP_REG 8'hf9

// Operation subopcodes
`define MBR_SUB_COND_LIM 8'h20
`define MBR_SUB_JMP_I 8'h20
`define MBR_SUB_CALL_I 8'h21
`define MBR_SUB_SLEEP 8'h28
`define MBR_SUB_RET 8'h00
`define MBR_SUB_EXIT 8'h02
`define MBR_SUB_JMP_R 8'h04
`define MBR_SUB_CALL_R 8'h05

// Condition subopcodes (low five bits)
`define MBR_CC_C 5'h08
`define MBR_CC_O 5'h09
`define MBR_CC_S 5'h0a
`define MBR_CC_Z 5'h0b
`define MBR_CC_A 5'h0c
`define MBR_CC_NA 5'h0d
`define MBR_CC_ALWAYS 5'h0e
`define MBR_CC_NC 5'h18
`define MBR_CC_NO 5'h19
`define MBR_CC_NS 5'h1a
`define MBR_CC_NZ 5'h1b
`define MBR_CC_SG 5'h1c
`define MBR_CC_SLE 5'h1d
`define MBR_CC_SL 5'h1e
`define MBR_CC_SGE 5'h1f
`define MBR_MIN_SIGNED_VER 3

// Condition word bit positions
`define MBR_FLAG_C 8
`define MBR_FLAG_O 9
`define MBR_FLAG_S 10
`define MBR_FLAG_Z 11
`define MBR_FLAG_W 12

// Run states
`define MBR_RUN_STOPPED 2'h0
`define MBR_RUN_RUNNING 2'h1
`define MBR_RUN_SLEEPING 2'h2

// Stack step and timing counts in cycles
`define MBR_SP_STEP 32'h0000_0004
`define MBR_BR_TAKEN_CYC 3'h4
`define MBR_SEQ_OVERHEAD 3'h2
`define MBR_RET_OVERHEAD 3'h3
`define MBR_WORD_BYTES 4'h4

`endif

// ==== logic/mbr_cond_eval.v ====
`include "mbr_consts.vh"

module mbr_cond_eval #(
    parameter CORE_VERSION = 3
) (
    input wire [4:0] cc,
    input wire [11:0] flags,
    output reg cond,
    output reg valid
);
    wire flg_c = flags[`MBR_FLAG_C];
    wire flg_o = flags[`MBR_FLAG_O];
    wire flg_s = flags[`MBR_FLAG_S];
    wire flg_z = flags[`MBR_FLAG_Z];
    wire ovs = flg_o ^ flg_s;
    wire signed_ok = (CORE_VERSION >= `MBR_MIN_SIGNED_VER);

    // Condition decode from the five-bit condition code
    always @* begin
        cond = 1'b0;
        valid = 1'b1;
        if (cc[4:3] == 2'b00) begin
            cond = flags[cc[2:0]];
        end else if (cc[4:3] == 2'b10) begin
            cond = ~flags[cc[2:0]];
        end else begin
            case (cc)
                `MBR_CC_C: cond = flg_c;
                `MBR_CC_O: cond = flg_o;
                `MBR_CC_S: cond = flg_s;
                `MBR_CC_Z: cond = flg_z;
                `MBR_CC_A: cond = ~flg_c & ~flg_z;
                `MBR_CC_NA: cond = flg_c | flg_z;
                `MBR_CC_ALWAYS: cond = 1'b1;
                `MBR_CC_NC: cond = ~flg_c;
                `MBR_CC_NO: cond = ~flg_o;
                `MBR_CC_NS: cond = ~flg_s;
                `MBR_CC_NZ: cond = ~flg_z;
                `MBR_CC_SG: begin
                    cond = ~ovs & ~flg_z;
                    valid = signed_ok;
                end
                `MBR_CC_SLE: begin
                    cond = ovs | flg_z;
                    valid = signed_ok;
                end
                `MBR_CC_SL: begin
                    cond = ovs;
                    valid = signed_ok;
                end
                `MBR_CC_SGE: begin
                    cond = ~ovs;
                    valid = signed_ok;
                end
                default: valid = 1'b0;
            endcase
        end
    end
endmodule // mbr_cond_eval

// ==== logic/mbr_run_state.v ====
`include "mbr_consts.vh"

module mbr_run_state (
    input wire clk,
    input wire resetn,
    input wire crypto_reset,
    input wire start_cmd,
    input wire exit_evt,
    input wire double_trap,
    input wire sleep_evt,
    input wire irq_pending,
    input wire scrubber_done,
    output reg [1:0] run_state_ff,
    output reg exit_irq_ff
);
    reg [1:0] nxt_run_state;
    reg nxt_exit_irq;

    // Next state; crypto reset first, then scrubber done, then the events of the present state
    always @* begin
        nxt_run_state = run_state_ff;
        nxt_exit_irq = 1'b0;
        if (crypto_reset) begin
            nxt_run_state = `MBR_RUN_RUNNING;
        end else if (scrubber_done &&
                     run_state_ff != `MBR_RUN_STOPPED) begin
            nxt_run_state = `MBR_RUN_STOPPED;
            nxt_exit_irq = 1'b1;
        end else begin
            case (run_state_ff)
                `MBR_RUN_STOPPED: begin
                    if (start_cmd)
                        nxt_run_state = `MBR_RUN_RUNNING;
                end
                `MBR_RUN_RUNNING: begin
                    if (exit_evt || double_trap) begin
                        nxt_run_state = `MBR_RUN_STOPPED;
                        nxt_exit_irq = 1'b1;
                    end else if (sleep_evt) begin
                        nxt_run_state = `MBR_RUN_SLEEPING;
                    end
                end
                `MBR_RUN_SLEEPING: begin
                    if (irq_pending)
                        nxt_run_state = `MBR_RUN_RUNNING;
                end
                default: nxt_run_state = `MBR_RUN_STOPPED;
            endcase
        end
    end

    // State register; plain reset stops the core with no exit pulse
    always @(posedge clk) begin
        if (!resetn) begin
            run_state_ff <= `MBR_RUN_STOPPED;
            exit_irq_ff <= 1'b0;
        end else begin
            run_state_ff <= nxt_run_state;
            exit_irq_ff <= nxt_exit_irq;
        end
    end
endmodule // mbr_run_state

// ==== tb/mbr_data_mem.sv ====
module mbr_data_mem (
    input wire logic clk,
    input wire logic dmem_rd_ff,
    input wire logic dmem_wr_ff,
    input wire logic [31:0] dmem_addr_ff,
    input wire logic [31:0] dmem_wdata_ff,
    output logic [31:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem_ff [0:63];
    initial dmem_rdata = 32'h5a5a_5a5a;
    // Word store, read answer one cycle later, idle bus keeps toggling
    always @(posedge clk) begin
        if (dmem_wr_ff) begin
            mem_ff[dmem_addr_ff[7:2]] <= dmem_wdata_ff;
        end
        if (dmem_rd_ff) begin
            dmem_rdata <= mem_ff[dmem_addr_ff[7:2]];
        end else begin
            dmem_rdata <= ~dmem_rdata;
        end
    end
endmodule // mbr_data_mem

// ==== tb/mbr_branch_ctrl_assertions.sv ====
`include "mbr_consts.vh"

module mbr_branch_ctrl_assertions #(
    parameter CORE_VERSION = 3,
    parameter DMEM_AW = 16
) (
    input wire clk,
    input wire resetn,
    input wire crypto_reset,
    input wire start_cmd,
    input wire double_trap,
    input wire scrubber_done,
    input wire irq_pending,
    input wire insn_valid,
    input wire [7:0] insn_opcode,
    input wire [7:0] insn_subop,
    input wire [2:0] insn_len,
    input wire [31:0] cond_word,
    input wire insn_ready_ff,
    input wire insn_done_ff,
    input wire insn_taken_ff,
    input wire [31:0] program_counter_ff,
    input wire [31:0] stack_pointer_ff,
    input wire dmem_rd_ff,
    input wire dmem_wr_ff,
    input wire [31:0] dmem_addr_ff,
    input wire [31:0] dmem_wdata_ff,
    input wire [1:0] run_state_ff,
    input wire exit_irq_ff
);
    wire take;
    wire stopped;
    wire running;
    // Instruction accepted at this edge
    assign take = insn_valid && insn_ready_ff && running && !crypto_reset;
    assign stopped = run_state_ff == `MBR_RUN_STOPPED;
    assign running = run_state_ff == `MBR_RUN_RUNNING;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Run-state transitions, the exit line, branch timing and stack accesses
    AST_RESET_STOP: assert property (disable iff (1'b0)
        !resetn |=> stopped && !exit_irq_ff) else $error("reset not stop");
    AST_CRYPTO_RUN: assert property (
        crypto_reset |=> running && !exit_irq_ff) else $error("crypto");
    AST_START: assert property (
        stopped && start_cmd && !crypto_reset && !scrubber_done |=> running)
        else $error("start ignored");
    AST_STOP_DEAF: assert property (
        stopped && !start_cmd && !crypto_reset |=> stopped)
        else $error("stopped core left state");
    AST_WAKE: assert property (
        run_state_ff == `MBR_RUN_SLEEPING && irq_pending && !scrubber_done
        |=> running) else $error("no wake");
    AST_TRAP: assert property (
        running && double_trap && !crypto_reset && !scrubber_done
        |=> stopped && exit_irq_ff) else $error("double trap");
    AST_EXIT_PULSE: assert property (
        exit_irq_ff |-> stopped && $past(run_state_ff) != `MBR_RUN_STOPPED
        ##1 !exit_irq_ff) else $error("exit pulse");
    AST_TAKEN_TIME: assert property (
        take && insn_opcode[7:1] == 7'h7a && insn_subop == 8'h0e
        |=> !insn_done_ff ##1 !insn_done_ff
        ##[2:3] (insn_done_ff && insn_taken_ff)) else $error("taken time");
    AST_NT_TIME: assert property (
        take && insn_opcode[7:1] == 7'h7a && insn_subop == 8'h08
        && !cond_word[8]
        |=> insn_done_ff && !insn_taken_ff) else $error("not taken time");
    AST_RET_READ: assert property (
        take && insn_opcode == 8'hf8 && insn_subop == 8'h00
        |=> dmem_rd_ff && dmem_addr_ff == stack_pointer_ff)
        else $error("return read");
    AST_CALL_PUSH: assert property (
        take && insn_opcode == 8'hf9 && insn_subop == 8'h05
        |=> dmem_wr_ff && dmem_addr_ff == stack_pointer_ff
        && dmem_wdata_ff == $past(program_counter_ff) + $past(insn_len))
        else $error("call push");
    AST_SP_ALIGN: assert property (
        stack_pointer_ff[1:0] == 2'b00 && (stack_pointer_ff >> DMEM_AW) == 0)
        else $error("stack pointer alignment");
    // Main scenarios reached
    COV_EXIT: cover property (exit_irq_ff);
    COV_WAKE: cover property (run_state_ff == `MBR_RUN_SLEEPING ##1 running);
    COV_PUSH: cover property (dmem_wr_ff);
endmodule // mbr_branch_ctrl_assertions

bind mbr_branch_ctrl mbr_branch_ctrl_assertions #(
    .CORE_VERSION(CORE_VERSION),
    .DMEM_AW(DMEM_AW)
) i_mbr_branch_ctrl_assertions (
    .clk, .resetn, .crypto_reset, .start_cmd, .double_trap,
    .scrubber_done, .irq_pending, .insn_valid, .insn_opcode, .insn_subop,
    .insn_len, .cond_word, .insn_ready_ff, .insn_done_ff, .insn_taken_ff,
    .program_counter_ff, .stack_pointer_ff, .dmem_rd_ff, .dmem_wr_ff,
    .dmem_addr_ff,
    .dmem_wdata_ff, .run_state_ff, .exit_irq_ff
);

// ==== tb/mbr_branch_ctrl_bench.sv ====
module mbr_branch_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, crypto_reset, start_cmd, double_trap, scrubber_done;
    logic irq_pending, insn_valid, insn_ready_ff, insn_done_ff;
    logic insn_taken_ff, insn_invalid_ff, dmem_rd_ff, dmem_wr_ff, exit_irq_ff;
    logic [7:0] insn_opcode, insn_subop;
    logic [15:0] insn_imm;
    logic [2:0] insn_len, tgt_len;
    logic [31:0] insn_reg, cond_word, dmem_rdata, program_counter_ff;
    logic [31:0] stack_pointer_ff, dmem_addr_ff, dmem_wdata_ff;
    logic [1:0] run_state_ff;
    int fail_count, total_checks, cycles, n;
    // Condition code, condition word flags, expected outcome
    logic [23:0] tbl [0:23] = '{24'h08_1001, 24'h08_0000, 24'h09_2001,
        24'h0a_4001, 24'h0b_8001, 24'h0c_0001, 24'h0c_1000, 24'h0d_8001,
        24'h0d_0000, 24'h0e_f001, 24'h03_0081, 24'h13_0080, 24'h13_0001,
        24'h18_0001, 24'h19_2000, 24'h1a_0001, 24'h1b_8000, 24'h1c_6001,
        24'h1c_8000, 24'h1d_2001, 24'h1e_4001, 24'h1e_6000, 24'h1f_6001,
        24'h1f_2000};

    mbr_branch_ctrl #(.CORE_VERSION(3), .DMEM_AW(16)) i_mbr_branch_ctrl (
        .clk, .resetn, .crypto_reset, .start_cmd, .double_trap,
        .scrubber_done, .irq_pending, .insn_valid, .insn_opcode, .insn_subop,
        .insn_imm, .insn_len, .insn_reg, .cond_word, .tgt_len, .dmem_rdata,
        .insn_ready_ff, .insn_done_ff, .insn_taken_ff, .insn_invalid_ff,
        .program_counter_ff, .stack_pointer_ff, .dmem_rd_ff, .dmem_wr_ff,
        .dmem_addr_ff, .dmem_wdata_ff, .run_state_ff, .exit_irq_ff);
    mbr_data_mem i_mbr_data_mem (.clk, .dmem_rd_ff, .dmem_wr_ff,
        .dmem_addr_ff, .dmem_wdata_ff, .dmem_rdata);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Offer one instruction, count cycles to done or invalid
    task automatic issue(input logic [7:0] op, input logic [7:0] sub,
        input logic [15:0] imm, input logic [2:0] len);
        @(negedge clk);
        insn_opcode = op;
        insn_subop = sub;
        insn_imm = imm;
        insn_len = len;
        insn_valid = 1'b1;
        @(negedge clk);
        insn_valid = 1'b0;
        n = 1;
        while (insn_done_ff !== 1'b1 && insn_invalid_ff !== 1'b1 && n < 9)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    task automatic t_cond;
        logic [31:0] pc0, tg;
        for (int i = 0; i < 24; i++) begin
            cond_word = {20'h0_0000, tbl[i][15:4]};
            pc0 = program_counter_ff;
            if (i % 2 == 1) begin
                tg = pc0 + 32'h0000_0106;
                issue(8'hf5, tbl[i][23:16], 16'h0106, 3'h3);
            end else begin
                tg = pc0 - 32'h0000_000a;
                issue(8'hf4, tbl[i][23:16], 16'h00f6, 3'h2);
            end
            if (tbl[i][0] == 1'b0) begin
                tg = pc0 + {29'h0, insn_len};
            end
            chk(insn_taken_ff, {31'h0, tbl[i][0]});
            chk(program_counter_ff, tg);
            chk(n, !tbl[i][0] ? 1 : (tg[1:0] == 2'h3 ? 5 : 4));
        end
    endtask

    task automatic t_call;
        issue(8'hf4, 8'h20, 16'hff80, 3'h2);
        chk(program_counter_ff, 32'h0000_0080);
        insn_reg = 32'h0000_0123;
        issue(8'hf9, 8'h04, 16'h0000, 3'h2);
        chk(program_counter_ff, 32'h0000_0123);
        chk(n, 5);
        issue(8'hf5, 8'h21, 16'h8234, 3'h3);
        chk(program_counter_ff, 32'h0000_8234);
        chk(stack_pointer_ff, 32'h0000_fffc);
        insn_reg = 32'h0000_0300;
        issue(8'hf9, 8'h05, 16'h0000, 3'h2);
        chk(dmem_wdata_ff, 32'h0000_8236);
        chk(stack_pointer_ff, 32'h0000_fff8);
        issue(8'hf8, 8'h00, 16'h0000, 3'h1);
        chk(program_counter_ff, 32'h0000_8236);
        chk(stack_pointer_ff, 32'h0000_fffc);
        chk(dmem_addr_ff, 32'h0000_fff8);
        chk(n, 5);
        issue(8'hf8, 8'h00, 16'h0000, 3'h1);
        chk(program_counter_ff, 32'h0000_0126);
        chk(stack_pointer_ff, 32'h0000_0000);
    endtask

    task automatic t_misc;
        logic [31:0] pc0;
        pc0 = program_counter_ff;
        issue(8'h00, 8'h00, 16'h0000, 3'h2);
        chk(insn_invalid_ff, 1);
        issue(8'hf4, 8'h0f, 16'h0000, 3'h2);
        chk(insn_invalid_ff, 1);
        chk(program_counter_ff, pc0);
        cond_word = 32'h0000_0100;
        issue(8'hf4, 8'h28, 16'h0003, 3'h2);
        chk(run_state_ff, 2'h1);
        chk(program_counter_ff, pc0 + 32'h0000_0002);
        cond_word = 32'h0000_0008;
        issue(8'hf4, 8'h28, 16'h0003, 3'h2);
        chk(run_state_ff, 2'h2);
        pulse(irq_pending);
        chk(run_state_ff, 2'h1);
        chk(program_counter_ff, pc0 + 32'h0000_0002);
        issue(8'hf8, 8'h02, 16'h0000, 3'h2);
        chk(run_state_ff, 2'h0);
        chk(exit_irq_ff, 1);
        chk(program_counter_ff, pc0 + 32'h0000_0004);
        @(negedge clk);
        chk(exit_irq_ff, 0);
    endtask

    task automatic t_state;
        pulse(irq_pending);
        chk(run_state_ff, 2'h0);
        pulse(start_cmd);
        chk(run_state_ff, 2'h1);
        pulse(double_trap);
        chk({exit_irq_ff, run_state_ff}, 3'h4);
        pulse(crypto_reset);
        chk({exit_irq_ff, run_state_ff}, 3'h1);
        pulse(scrubber_done);
        chk({exit_irq_ff, run_state_ff}, 3'h4);
        pulse(start_cmd);
        resetn = 1'b0;
        @(negedge clk);
        resetn = 1'b1;
        chk({exit_irq_ff, run_state_ff}, 3'h0);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 2000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        {crypto_reset, start_cmd, double_trap, scrubber_done} = 4'h0;
        {irq_pending, insn_valid, insn_opcode, insn_subop} = 18'h0;
        {insn_imm, insn_len, insn_reg, cond_word} = 83'h0;
        tgt_len = 3'h2;
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk({insn_ready_ff, run_state_ff, exit_irq_ff}, 4'h8);
        chk(program_counter_ff, 32'h0000_0000);
        issue(8'hf4, 8'h0e, 16'h0010, 3'h2);
        chk(program_counter_ff, 32'h0000_0000);
        pulse(start_cmd);
        chk(run_state_ff, 2'h1);
        t_cond();
        t_call();
        t_misc();
        t_state();
        stop_test();
    end
endmodule // mbr_branch_ctrl_bench
